// ===== common/pmc_map.vh
// pmc_map.vh: register offsets, field positions, frame and timing
// constants of the management and configuration block.
// assumes: included by bare name from the design files under rtl/.
`ifndef PMC_MAP_VH
`define PMC_MAP_VH

////////////////////////////////////////////////////////////////////////
// ahb register byte offsets
`define PMC_OFF_CTRL        8'h00
`define PMC_OFF_STATUS      8'h04
`define PMC_OFF_IRQ_STAT    8'h08
`define PMC_OFF_IRQ_CLR     8'h0C
`define PMC_OFF_IRQ_EN      8'h10
`define PMC_OFF_MGMT_LOG    8'h14

// control and status fields
`define PMC_CTRL_AN_START   0
`define PMC_ST_SGMII        0
`define PMC_ST_AN_DONE      1
`define PMC_ST_AN_BUSY      2
`define PMC_ST_LOOPBACK     3
`define PMC_ST_POWERDOWN    4
`define PMC_ST_ISOLATE      5

// interrupt status / clear / enable layout
`define PMC_IRQ_W           3
`define PMC_IRQ_AN_DONE     0
`define PMC_IRQ_MGMT_WR     1
`define PMC_IRQ_MGMT_RD     2

// static configuration word
`define PMC_CFG_RESERVED    0
`define PMC_CFG_LOOPBACK    1
`define PMC_CFG_POWERDOWN   2
`define PMC_CFG_ISOLATE     3

////////////////////////////////////////////////////////////////////////
// serial management frame
`define PMC_PRE_BITS        6'd32
`define PMC_HDR_LAST        4'd11
`define PMC_DATA_LAST       4'd15
`define PMC_OP_READ         2'b10
`define PMC_OP_WRITE        2'b01
`define PMC_REG_CTRL        5'h00
`define PMC_REG_STAT        5'h01
`define PMC_REG_STD         5'h10
`define PMC_MC_RESTART_AN   9
`define PMC_MC_ISOLATE      10
`define PMC_MC_POWERDOWN    11
`define PMC_MC_LOOPBACK     14
`define PMC_MS_AN_DONE      5
`define PMC_MD_SGMII        0
`define PMC_MD_IRQ_EN       1
`define PMC_MD_IRQ_PEND     2

////////////////////////////////////////////////////////////////////////
// timing
`define PMC_MDC_MAX_KHZ     2500
`define PMC_CLK_PERIOD_NS   25
`define PMC_LT_UNIT_CYCLES  4096
`define PMC_LT_UNIT_PER_NS  8

`endif

// ===== rtl/pmc_top.v
// pmc_top.v: serial management slave, configuration word, link timer
// and standard select of the gigabit coding sublayer, with an ahb-lite
// register port. assumes one 40 MHz clock; every pin outside the ahb port and reset is asynchronous.
//
// Notes on behaviour
// R1: far controller keeps mdc at most 2.5 MHz; the bench controller runs mdc at 5 MHz.
// R2: tri-state control low only while driving data.
// R3: unused management data input is tied high.
// R4: five-bit strap picks the answering address.
// R5: bit 1 loops back or requests external wrap.
// R6: bit 2 powers down until reset; tbi ignores.
// R7: bit 3 requests electrical isolation of gmii.
// R8: bit 0 is reserved, no function.
// R9: configuration word driven synchronous to reference.
// R10: link timer is setting times 4096 units.
// R11: completion interrupt, enabled and cleared by management.
// R12: dynamic mode picks per-standard timer setting.
// R13: reset default standard from the select input.
// R14: management write overrides standard after reset.
// R15: dynamic mode always includes the management port.
// R16: reset high returns the whole block to defaults.
// R17: clause 22 frames, answering only strapped address.
//
// The placing of the registers and the AHB-Lite slave port were chosen for this implementation.
`include "pmc_map.vh"
`default_nettype none

module pmc_top #(
    parameter TBI_VARIANT    = 0,
    parameter DYNAMIC_SWITCH = 1,
    parameter MDIO_PRESENT   = 1,
    parameter TIMER_SCALE    = (`PMC_LT_UNIT_CYCLES * `PMC_LT_UNIT_PER_NS)
                               / `PMC_CLK_PERIOD_NS,
    parameter CNT_W          = 21
) (
    input  wire        i_ref_clk,
    input  wire        i_reset,
    input  wire        i_hsel,
    input  wire [31:0] i_haddr,
    input  wire [1:0]  i_htrans,
    input  wire        i_hwrite,
    input  wire [2:0]  i_hsize,
    input  wire [31:0] i_hwdata,
    input  wire        i_hready,
    output wire [31:0] o_hrdata,
    output wire        o_hreadyout,
    output wire        o_hresp,
    input  wire        i_mdc,
    input  wire        i_mdio_in,
    output wire        o_mdio_out,
    output wire        o_mdio_tri,
    output wire        o_mdio_oe,
    input  wire [4:0]  i_phy_addr,
    input  wire [3:0]  i_config_vec,
    input  wire [8:0]  i_link_timer_value,
    input  wire [8:0]  i_link_timer_basex,
    input  wire [8:0]  i_link_timer_sgmii,
    input  wire        i_basex_or_sgmii,
    output wire        o_loopback,
    output wire        o_ext_wrap,
    output wire        o_powerdown,
    output wire        o_isolate,
    output wire        o_std_sgmii,
    output wire        o_an_busy,
    output wire        o_negotiation_done_irq,
    output wire        o_irq
);

    localparam ST_PRE   = 3'd0;
    localparam ST_START = 3'd1;
    localparam ST_HDR   = 3'd2;
    localparam ST_TA    = 3'd3;
    localparam ST_DATA  = 3'd4;
    localparam SYNC_W   = 39;
    localparam MGMT_ON  = (MDIO_PRESENT != 0) || (DYNAMIC_SWITCH != 0);

    // setting times the scaled unit, cut to the counter width
    function [CNT_W-1:0] pmc_lt_cycles;
        input [8:0] setting;
        reg   [31:0] prod;
        begin
            prod = setting * TIMER_SCALE;
            pmc_lt_cycles = prod[CNT_W-1:0];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // two-flop synchronisers for every management, strap and configuration pin
    wire [SYNC_W-1:0] pin_vec = {i_mdc, i_mdio_in, i_phy_addr,
                                 i_config_vec, i_link_timer_value,
                                 i_link_timer_basex, i_link_timer_sgmii,
                                 i_basex_or_sgmii};
    reg  [SYNC_W-1:0] sync1_r;
    reg  [SYNC_W-1:0] sync2_r;
    reg               mdc_d_r;

    always @(posedge i_ref_clk) begin
        if (i_reset) begin
            sync1_r <= {SYNC_W{1'b0}};
            sync2_r <= {SYNC_W{1'b0}};
            mdc_d_r <= 1'b0;
        end else begin
            sync1_r <= pin_vec;
            sync2_r <= sync1_r;
            mdc_d_r <= sync2_r[38];
        end
    end

    wire       mdc_s    = sync2_r[38];
    wire       mdi_s    = sync2_r[37];
    wire [4:0] phy_s    = sync2_r[36:32];
    wire [3:0] cfg_s    = sync2_r[31:28];
    wire [8:0] lt_val_s = sync2_r[27:19];
    wire [8:0] lt_bx_s  = sync2_r[18:10];
    wire [8:0] lt_sg_s  = sync2_r[9:1];
    wire       bos_s    = sync2_r[0];
    // mdc is slow against the 40 MHz clock, so edges are found by sampling
    wire       mdc_rise = mdc_s & ~mdc_d_r;

    ////////////////////////////////////////////////////////////////////
    // serial management frame engine
    reg  [2:0]  st_r;
    reg  [5:0]  pre_cnt_r;
    reg  [3:0]  bit_cnt_r;
    reg  [11:0] hdr_r;
    reg  [15:0] sh_r;
    reg         mdo_r;
    reg         tri_r;
    reg  [15:0] rd_data;
    wire [11:0] hdr_nxt  = {hdr_r[10:0], mdi_s};
    wire        addr_hit = MGMT_ON && (hdr_r[9:5] == phy_s); // [R4] [R15]
    wire        rd_hit   = addr_hit && (hdr_r[11:10] == `PMC_OP_READ);
    wire        wr_hit   = addr_hit && (hdr_r[11:10] == `PMC_OP_WRITE);
    wire [4:0]  reg_sel  = hdr_r[4:0];
    wire        frame_end = mdc_rise && (st_r == ST_DATA)
                            && (bit_cnt_r == `PMC_DATA_LAST);
    wire        mgmt_wr  = frame_end && wr_hit;                   // [R17]
    wire        mgmt_rd  = frame_end && rd_hit;
    wire [15:0] wr_word  = {sh_r[14:0], mdi_s};

    // an idle line reads as ones, so a tied-high input never starts
    // a frame [R3]
    always @(posedge i_ref_clk) begin
        if (i_reset) begin                                        // [R16]
            st_r      <= ST_PRE;
            pre_cnt_r <= 6'h00;
            bit_cnt_r <= 4'h0;
            hdr_r     <= 12'h000;
            sh_r      <= 16'h0000;
            mdo_r     <= 1'b1;
            tri_r     <= 1'b1;
        end else if (mdc_rise) begin
            case (st_r)
                ST_PRE: begin                                     // [R17]
                    if (mdi_s) begin
                        if (pre_cnt_r != `PMC_PRE_BITS)
                            pre_cnt_r <= pre_cnt_r + 6'h01;
                    end else if (pre_cnt_r == `PMC_PRE_BITS) begin
                        st_r      <= ST_START;
                        pre_cnt_r <= 6'h00;
                    end else begin
                        pre_cnt_r <= 6'h00;
                    end
                end
                ST_START: begin
                    bit_cnt_r <= 4'h0;
                    st_r      <= mdi_s ? ST_HDR : ST_PRE;
                end
                ST_HDR: begin
                    hdr_r <= hdr_nxt;
                    if (bit_cnt_r == `PMC_HDR_LAST) begin
                        st_r      <= ST_TA;
                        bit_cnt_r <= 4'h0;
                    end else begin
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end
                end
                ST_TA: begin
                    // first turnaround bit stays released, second is 0
                    if (bit_cnt_r == 4'h0) begin
                        bit_cnt_r <= 4'h1;
                        if (rd_hit) begin
                            tri_r <= 1'b0;                        // [R2]
                            mdo_r <= 1'b0;
                        end
                    end else begin
                        st_r      <= ST_DATA;
                        bit_cnt_r <= 4'h0;
                        sh_r      <= {rd_data[14:0], 1'b0};
                        mdo_r     <= rd_hit ? rd_data[15] : 1'b1;
                    end
                end
                ST_DATA: begin
                    sh_r <= wr_word;
                    if (bit_cnt_r == `PMC_DATA_LAST) begin
                        st_r  <= ST_PRE;
                        tri_r <= 1'b1;                            // [R2]
                        mdo_r <= 1'b1;
                    end else begin
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                        if (rd_hit)
                            mdo_r <= sh_r[15];
                    end
                end
                default: begin
                    st_r  <= ST_PRE;
                    tri_r <= 1'b1;
                end
            endcase
        end
    end

    assign o_mdio_out = mdo_r;
    assign o_mdio_tri = tri_r;
    assign o_mdio_oe  = ~tri_r;

    ////////////////////////////////////////////////////////////////////
    // management registers, standard select and power-down latch
    reg        m_loop_r;
    reg        m_iso_r;
    reg        m_irq_en_r;
    reg        m_pend_r;
    reg        std_r;
    reg  [1:0] std_ld_r;
    reg        pdn_r;
    reg        an_done_r;
    reg        an_busy_r;
    reg [20:0] mgmt_log_r;
    wire       an_event;
    wire       m_restart = mgmt_wr && (reg_sel == `PMC_REG_CTRL)
                           && wr_word[`PMC_MC_RESTART_AN];
    wire       m_std_wr  = mgmt_wr && (reg_sel == `PMC_REG_STD);
    wire       m_pdn_req = (mgmt_wr && (reg_sel == `PMC_REG_CTRL)
                           && wr_word[`PMC_MC_POWERDOWN])
                           || cfg_s[`PMC_CFG_POWERDOWN];

    always @* begin
        rd_data = 16'h0000;
        case (reg_sel)
            `PMC_REG_CTRL: begin
                rd_data[`PMC_MC_LOOPBACK]  = m_loop_r;
                rd_data[`PMC_MC_POWERDOWN] = pdn_r;
                rd_data[`PMC_MC_ISOLATE]   = m_iso_r;
            end
            `PMC_REG_STAT: rd_data[`PMC_MS_AN_DONE] = an_done_r;
            `PMC_REG_STD: begin
                rd_data[`PMC_MD_SGMII]    = std_r;
                rd_data[`PMC_MD_IRQ_EN]   = m_irq_en_r;
                rd_data[`PMC_MD_IRQ_PEND] = m_pend_r;
            end
            default: rd_data = 16'h0000;
        endcase
    end

    always @(posedge i_ref_clk) begin
        if (i_reset) begin
            m_loop_r   <= 1'b0;
            m_iso_r    <= 1'b0;
            m_irq_en_r <= 1'b0;
            m_pend_r   <= 1'b0;
            std_r      <= 1'b0;
            std_ld_r   <= 2'b00;
            pdn_r      <= 1'b0;
            mgmt_log_r <= 21'h000000;
        end else begin
            if (mgmt_wr)
                mgmt_log_r <= {reg_sel, wr_word};
            if (mgmt_wr && (reg_sel == `PMC_REG_CTRL)) begin
                m_loop_r <= wr_word[`PMC_MC_LOOPBACK];
                m_iso_r  <= wr_word[`PMC_MC_ISOLATE];
            end
            if (m_std_wr)
                m_irq_en_r <= wr_word[`PMC_MD_IRQ_EN];
            // a completion landing on the clearing write still sets [R11]
            m_pend_r <= (m_pend_r & ~(m_std_wr
                         && wr_word[`PMC_MD_IRQ_PEND])) | an_event;
            // synchroniser needs a few cycles before the strap is valid
            if (std_ld_r != 2'b11) begin
                std_ld_r <= std_ld_r + 2'b01;
                std_r    <= bos_s;                                // [R13]
            end else if (m_std_wr && (DYNAMIC_SWITCH != 0)) begin
                std_r <= wr_word[`PMC_MD_SGMII];                  // [R14]
            end
            // only reset brings the transceiver back up
            if ((TBI_VARIANT == 0) && m_pdn_req)
                pdn_r <= 1'b1;                                    // [R6]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // auto-negotiation link timer
    reg  [CNT_W-1:0] lt_cnt_r;
    wire [8:0]       lt_setting = (DYNAMIC_SWITCH == 0) ? lt_val_s :
                                  (std_r ? lt_sg_s : lt_bx_s);    // [R12]
    wire             ahb_start;
    wire             an_start = ahb_start | m_restart;

    assign an_event = an_busy_r && (lt_cnt_r <= {{(CNT_W-1){1'b0}}, 1'b1});

    always @(posedge i_ref_clk) begin
        if (i_reset) begin
            an_busy_r <= 1'b0;
            an_done_r <= 1'b0;
            lt_cnt_r  <= {CNT_W{1'b0}};
        end else if (an_start) begin
            an_busy_r <= 1'b1;
            an_done_r <= 1'b0;
            lt_cnt_r  <= pmc_lt_cycles(lt_setting);               // [R10]
        end else if (an_event) begin
            an_busy_r <= 1'b0;
            an_done_r <= 1'b1;
        end else if (an_busy_r) begin
            lt_cnt_r <= lt_cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // configuration outputs, registered
    reg  lb_r;
    reg  wrap_r;
    reg  iso_r;
    reg  ndi_r;
    wire loop_req = cfg_s[`PMC_CFG_LOOPBACK] | m_loop_r;
    // cfg_s reserved bit is deliberately left unread [R8]

    always @(posedge i_ref_clk) begin
        if (i_reset) begin
            lb_r   <= 1'b0;
            wrap_r <= 1'b0;
            iso_r  <= 1'b0;
            ndi_r  <= 1'b0;
        end else begin
            lb_r   <= (TBI_VARIANT == 0) && loop_req;             // [R5]
            wrap_r <= (TBI_VARIANT != 0) && loop_req;             // [R5]
            iso_r  <= cfg_s[`PMC_CFG_ISOLATE] | m_iso_r;          // [R7]
            ndi_r  <= m_pend_r & m_irq_en_r;                      // [R11]
        end
    end

    assign o_loopback             = lb_r;
    assign o_ext_wrap             = wrap_r;
    assign o_powerdown            = pdn_r;
    assign o_isolate              = iso_r;
    assign o_std_sgmii            = std_r;
    assign o_an_busy              = an_busy_r;
    assign o_negotiation_done_irq = ndi_r;

    ////////////////////////////////////////////////////////////////////
    // ahb-lite slave: zero wait states, always OKAY
    reg  [31:0]           hrdata_r;
    reg                   wr_pend_r;
    reg  [7:0]            wr_addr_r;
    reg  [`PMC_IRQ_W-1:0] irq_stat_r;
    reg  [`PMC_IRQ_W-1:0] irq_en_r;
    reg  [31:0]           rd_mux;
    wire                  addr_ok = (i_haddr[31:8] == 24'h000000);
    wire                  ahb_act = i_hsel & i_htrans[1] & i_hready;
    wire                  wr_ctrl = wr_pend_r
                                    && (wr_addr_r == `PMC_OFF_CTRL);
    wire                  wr_clr  = wr_pend_r
                                    && (wr_addr_r == `PMC_OFF_IRQ_CLR);
    wire [`PMC_IRQ_W-1:0] irq_evt = {mgmt_rd, mgmt_wr, an_event};

    assign ahb_start = wr_ctrl && i_hwdata[`PMC_CTRL_AN_START];

    always @* begin
        rd_mux = 32'h00000000;
        if (addr_ok) begin
            case (i_haddr[7:0])
                `PMC_OFF_STATUS: begin
                    rd_mux[`PMC_ST_SGMII]     = std_r;
                    rd_mux[`PMC_ST_AN_DONE]   = an_done_r;
                    rd_mux[`PMC_ST_AN_BUSY]   = an_busy_r;
                    rd_mux[`PMC_ST_LOOPBACK]  = lb_r | wrap_r;
                    rd_mux[`PMC_ST_POWERDOWN] = pdn_r;
                    rd_mux[`PMC_ST_ISOLATE]   = iso_r;
                end
                `PMC_OFF_IRQ_STAT: rd_mux[`PMC_IRQ_W-1:0] = irq_stat_r;
                `PMC_OFF_IRQ_EN:   rd_mux[`PMC_IRQ_W-1:0] = irq_en_r;
                `PMC_OFF_MGMT_LOG: rd_mux[20:0] = mgmt_log_r;
                default:           rd_mux = 32'h00000000;
            endcase
        end
    end

    always @(posedge i_ref_clk) begin
        if (i_reset) begin
            hrdata_r   <= 32'h00000000;
            wr_pend_r  <= 1'b0;
            wr_addr_r  <= 8'h00;
            irq_stat_r <= {`PMC_IRQ_W{1'b0}};
            irq_en_r   <= {`PMC_IRQ_W{1'b0}};
        end else begin
            wr_pend_r <= ahb_act & i_hwrite & addr_ok;
            if (ahb_act)
                wr_addr_r <= i_haddr[7:0];
            if (ahb_act && !i_hwrite)
                hrdata_r <= rd_mux;
            if (wr_pend_r && (wr_addr_r == `PMC_OFF_IRQ_EN))
                irq_en_r <= i_hwdata[`PMC_IRQ_W-1:0];
            // a new event wins over a clear in the same cycle
            irq_stat_r <= (irq_stat_r & ~({`PMC_IRQ_W{wr_clr}}
                          & i_hwdata[`PMC_IRQ_W-1:0])) | irq_evt;
        end
    end

    assign o_hrdata    = hrdata_r;
    assign o_hreadyout = 1'b1;
    assign o_hresp     = 1'b0;
    assign o_irq       = |(irq_stat_r & irq_en_r);

endmodule // pmc_top

`default_nettype wire

// ===== testbench/pmc_chk.sv
// pmc_chk.sv: port-level assertions for pmc_top.
// assumes one clock domain with a synchronous active-high reset.
`default_nettype none
module pmc_chk #(
    parameter TIMER_SCALE = 4
) (
    input wire logic       i_ref_clk,
    input wire logic       i_reset,
    input wire logic [3:0] i_config_vec,
    input wire logic [8:0] i_link_timer_basex,
    input wire logic [8:0] i_link_timer_sgmii,
    input wire logic       i_basex_or_sgmii,
    input wire logic       o_mdio_tri,
    input wire logic       o_mdio_oe,
    input wire logic       o_loopback,
    input wire logic       o_ext_wrap,
    input wire logic       o_powerdown,
    input wire logic       o_isolate,
    input wire logic       o_std_sgmii,
    input wire logic       o_an_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_ref_clk);
    endclocking
    default disable iff (i_reset);
    logic [31:0] busy_cnt_r;
    logic [31:0] n_exp;
    // timer inputs are static, so the live setting is the one in use
    assign n_exp = (o_std_sgmii ? i_link_timer_sgmii : i_link_timer_basex)
                   * TIMER_SCALE;
    always @(posedge i_ref_clk) begin
        if (i_reset || !o_an_busy)
            busy_cnt_r <= 32'h0;
        else
            busy_cnt_r <= busy_cnt_r + 32'h1;
    end
    ////////////////////////////////////////////////////////////////////
    a_oe_inverse: assert property (
        o_mdio_oe == !o_mdio_tri) else $error("mdio enable mismatch");
    a_drive_hold: assert property (
        $fell(o_mdio_tri) |-> !o_mdio_tri [*8])
        else $error("mdio drive too short");
    a_loop_cfg: assert property (
        i_config_vec[1] [*6] |-> o_loopback) else $error("no loopback");
    a_no_wrap: assert property (
        !o_ext_wrap) else $error("wrap request in transceiver variant");
    a_pd_cfg: assert property (
        i_config_vec[2] [*6] |-> o_powerdown) else $error("no powerdown");
    a_pd_sticky: assert property (
        o_powerdown |=> o_powerdown) else $error("powerdown left");
    a_iso_cfg: assert property (
        i_config_vec[3] [*6] |-> o_isolate) else $error("no isolate");
    a_timer_len: assert property (
        $fell(o_an_busy) |-> busy_cnt_r >= n_exp && busy_cnt_r <= n_exp + 2)
        else $error("link timer length wrong");
    a_std_default: assert property (
        $fell(i_reset) |-> ##5 o_std_sgmii == i_basex_or_sgmii)
        else $error("reset default standard wrong");
    a_reset_idle: assert property (disable iff (1'b0)
        i_reset |=> o_mdio_tri && !o_powerdown && !o_an_busy)
        else $error("reset state wrong");
endmodule // pmc_chk

bind pmc_top pmc_chk #(.TIMER_SCALE(TIMER_SCALE)) u_chk (
    .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_config_vec(i_config_vec),
    .i_link_timer_basex(i_link_timer_basex),
    .i_link_timer_sgmii(i_link_timer_sgmii),
    .i_basex_or_sgmii(i_basex_or_sgmii), .o_mdio_tri(o_mdio_tri),
    .o_mdio_oe(o_mdio_oe), .o_loopback(o_loopback), .o_ext_wrap(o_ext_wrap),
    .o_powerdown(o_powerdown), .o_isolate(o_isolate),
    .o_std_sgmii(o_std_sgmii), .o_an_busy(o_an_busy));
`default_nettype wire

// ===== testbench/pmc_mdio_ctl.sv
// pmc_mdio_ctl.sv: behavioural management bus controller.
// assumes the line has a pull-up; mdc stands low between frames.
`default_nettype none
module pmc_mdio_ctl (
    input  wire logic i_dut_out,
    input  wire logic i_dut_tri,
    output var  logic o_mdc,
    output wire logic o_mdio
);
    timeunit 1ns;
    timeprecision 1ps;
    logic drv = 1'b1;
    initial o_mdc = 1'b0;
    // drv high means released: the pull-up then holds the line
    assign o_mdio = i_dut_tri ? drv : i_dut_out;
    ////////////////////////////////////////////////////////////////////
    // 200 ns period, data changes while mdc low
    task automatic bit_io(input logic b, output logic s);
        drv = b;
        #100 o_mdc = 1'b1;
        s = o_mdio;
        #100 o_mdc = 1'b0;
    endtask
    // clause 22 frame; read passes wd all ones so data bits are released
    task automatic frame(input logic [1:0] op, input logic [4:0] pa, ra,
                         input logic [15:0] wd, input int pre,
                         output logic [15:0] rd);
        logic s;
        logic [13:0] h;
        h = {2'b01, op, pa, ra};
        #7;
        for (int i = 0; i < pre; i++)
            bit_io(1'b1, s);
        for (int i = 13; i >= 0; i--)
            bit_io(h[i], s);
        bit_io(1'b1, s);
        bit_io(op[1], s);
        for (int i = 15; i >= 0; i--) begin
            bit_io(wd[i], s);
            rd[i] = s;
        end
        drv = 1'b1;
        #200;
    endtask
endmodule // pmc_mdio_ctl
`default_nettype wire

// ===== testbench/pmc_top_tb.sv
// pmc_top_tb.sv: self-checking bench for pmc_top.
// assumes the ahb slave is zero-wait and the timer scale is shortened.
`include "pmc_map.vh"
`default_nettype none
module pmc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam SCALE = 4;
    localparam logic [4:0] PHY = 5'h0B;
    logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic std0 = 1'b1, rd_ph = 1'b0;
    logic [31:0] haddr = 0, hwdata = 0, seed = 32'hB442F91E;
    logic [1:0]  htrans = 2'h0;
    logic [3:0]  cfg = 4'h0;
    logic [8:0]  ltv = 9'h0, ltb = 9'h1, lts = 9'h1;
    wire  [31:0] hrdata;
    wire         hready, hresp, mdc, mdio, mout, mtri, moe;
    wire         lb, ew, pd, iso, sg, busy, nirq, irq;
    int          errors = 0, checks = 0;
    logic [31:0] exp_q[$];
    always #12.5 clk = ~clk;
    pmc_top #(.TIMER_SCALE(SCALE)) dut (
        .i_ref_clk(clk), .i_reset(rst), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
        .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
        .o_hreadyout(hready), .o_hresp(hresp), .i_mdc(mdc),
        .i_mdio_in(mdio), .o_mdio_out(mout), .o_mdio_tri(mtri),
        .o_mdio_oe(moe), .i_phy_addr(PHY), .i_config_vec(cfg),
        .i_link_timer_value(ltv), .i_link_timer_basex(ltb),
        .i_link_timer_sgmii(lts), .i_basex_or_sgmii(std0),
        .o_loopback(lb), .o_ext_wrap(ew), .o_powerdown(pd),
        .o_isolate(iso), .o_std_sgmii(sg), .o_an_busy(busy),
        .o_negotiation_done_irq(nirq), .o_irq(irq));
    pmc_mdio_ctl m (.i_dut_out(mout), .i_dut_tri(mtri), .o_mdc(mdc),
                    .o_mdio(mdio));
    ////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic chk(input string n, input logic [31:0] got, exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic end_of_test;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic ahb(input logic w, input logic [31:0] a, d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rd_ph <= !w;
        do @(posedge clk); while (hready !== 1'b1);
        chk("hresp", 32'(hresp), 32'h0);
        rd_ph <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, exp);
        exp_q.push_back(exp);
        ahb(1'b0, a, 32'h0);
    endtask
    always @(posedge clk)
        if (rd_ph && hready === 1'b1)
            chk("hrdata", hrdata, exp_q.pop_front());
    task automatic mw(input logic [4:0] ra, input logic [15:0] d,
                      input logic [4:0] pa, input int pre);
        logic [15:0] r;
        m.frame(`PMC_OP_WRITE, pa, ra, d, pre, r);
        repeat (4) @(posedge clk);
    endtask
    task automatic mr(input logic [4:0] ra, input logic [15:0] exp);
        logic [15:0] r;
        m.frame(`PMC_OP_READ, PHY, ra, 16'hFFFF, 32, r);
        chk("mdio read", {16'h0, r}, {16'h0, exp});
    endtask
    task automatic run_timer;
        int n = 0;
        ahb(1'b1, `PMC_OFF_CTRL, 32'h1);
        while (busy !== 1'b1 && n < 8) begin
            @(posedge clk);
            n++;
        end
        while (busy !== 1'b0 && n < 300) begin
            @(posedge clk);
            n++;
        end
        chk("timer busy", 32'(busy), 32'h0);
        repeat (3) @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        #400000;
        errors++;
        end_of_test;
    end
    initial begin
        @(posedge clk);
        seed = xs(seed);
        ltv <= seed[8:0];
        ltb <= {6'h0, seed[2:0]} + 9'h1;
        lts <= {6'h0, seed[6:4]} + 9'h1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        rd(`PMC_OFF_STATUS, 32'h1);
        rd(`PMC_OFF_IRQ_EN, 32'h0);
        rd(32'h40, 32'h0);
        ahb(1'b1, `PMC_OFF_IRQ_EN, 32'h1);
        rd(`PMC_OFF_IRQ_EN, 32'h1);
        run_timer;
        rd(`PMC_OFF_STATUS, 32'h3);
        rd(`PMC_OFF_IRQ_STAT, 32'h1);
        chk("irq", 32'(irq), 32'h1);
        ahb(1'b1, `PMC_OFF_IRQ_CLR, 32'h1);
        @(posedge clk);
        chk("irq", 32'(irq), 32'h0);
        mw(`PMC_REG_STD, 16'h0006, PHY, 32);
        chk("done irq", 32'(nirq), 32'h0);
        rd(`PMC_OFF_STATUS, 32'h2);
        mw(`PMC_REG_STD, 16'h0001, PHY ^ 5'h01, 32);
        mw(`PMC_REG_STD, 16'h0001, PHY, 31);
        rd(`PMC_OFF_STATUS, 32'h2);
        rd(`PMC_OFF_MGMT_LOG, 32'h0010_0006);
        run_timer;
        chk("done irq", 32'(nirq), 32'h1);
        mr(`PMC_REG_STAT, 16'h0020);
        mr(`PMC_REG_STD, 16'h0006);
        rd(`PMC_OFF_IRQ_STAT, 32'h7);
        ahb(1'b1, `PMC_OFF_IRQ_EN, 32'h0);
        @(posedge clk);
        chk("irq masked", 32'(irq), 32'h0);
        ahb(1'b1, `PMC_OFF_IRQ_CLR, 32'h7);
        rd(`PMC_OFF_IRQ_STAT, 32'h0);
        mw(`PMC_REG_STD, 16'h0005, PHY, 32);
        chk("std", 32'({nirq, sg}), 32'h1);
        cfg <= 4'h1;
        repeat (8) @(posedge clk);
        chk("cfg outs", 32'({lb, pd, iso, ew}), 32'h0);
        cfg <= 4'hE;
        repeat (8) @(posedge clk);
        chk("cfg outs", 32'({lb, pd, iso, ew}), 32'hE);
        rd(`PMC_OFF_STATUS, 32'h3B);
        cfg <= 4'h0;
        repeat (8) @(posedge clk);
        chk("cfg outs", 32'({lb, pd, iso, ew}), 32'h4);
        std0 <= 1'b0;
        rst <= 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        chk("after reset", 32'({pd, sg, busy}), 32'h0);
        end_of_test;
    end
endmodule // pmc_top_tb
`default_nettype wire
